/* design/scf_spi_consts.svh */
`ifndef SCF_SPI_CONSTS_SVH
`define SCF_SPI_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SCF_FRAME_BITS 16
`define SCF_OP_HI 15
`define SCF_OP_LO 14
`define SCF_ADDR_HI 13
`define SCF_ADDR_LO 9
`define SCF_PN_BIT 8
`define SCF_DATA_HI 7
`define SCF_DATA_LO 0
`define SCF_LAST_BIT 5'h0f
`define SCF_HDR_BIT 5'h06
`define SCF_LOW_START 5'h08
`define SCF_CNT_SAT 5'h11
`define SCF_FLAG_ADDR 5'h11
`define SCF_FLAG_POS 4
`define SCF_REG_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCF_CLK_MHZ 50
`define SCF_STUCK_NS 2000000
`define SCF_LEAD_MIN_NS 550
`define SCF_LEAD_MAX_NS 2500
`define SCF_LEAD_SAT 8'hff

`endif

/* design/scf_pkg.sv */
package scf_pkg;

   // ----------------------------------------
   // Operation codes carried in the top two frame bits
   // ----------------------------------------
   typedef enum logic [1:0] {
      SCF_OP_READ  = 2'b00,
      SCF_OP_WRITE = 2'b01,
      SCF_OP_RSVD  = 2'b10,
      SCF_OP_FLAG  = 2'b11
   } scf_op_e;

   typedef logic [4:0] scf_addr_t;

endpackage

/* design/scf_spi_frame.sv */
// Behaviour
// - One frame is sixteen bits per select
// - Bits 15 and 14 form the op code
// - Bits 13 to 9 select the register
// - Bit 8 is parity on writes, next on reads
// - Bits 7 to 0 are the payload byte
// - Upper output byte is the fixed status
// - Lower byte: extended status, content or flags
// - No daisy chain; nothing shifts through
// - Op 00 reads back register content
// - Op 01 writes payload to the register
// - Op 11 reads the flags of the register
// - Write answers fixed then extended status
// - Op 00 read answers fixed status then content; op 11 read answers fixed status then flags
// - Every register reads back its current value
// - Accepted write completes before next frame
// - Select low over 2 ms sets flag
// - Flag set: write needs lead time window
// - Read clears flag, window no longer enforced
`timescale 1ns/1ps
`include "scf_spi_consts.svh"

module scf_spi_frame #(
   parameter int STUCK_CYC = `SCF_STUCK_NS * `SCF_CLK_MHZ / 1000,
   parameter int LEAD_MIN_NS = `SCF_LEAD_MIN_NS
) (
   input wire logic clk, // System clock, 50 MHz
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic sclk, // Link clock from the host
   input wire logic chip_select_n, // Frame select from the host, active low
   input wire logic mosi, // Serial data from the host
   output logic miso, // Serial data to the host
   output logic miso_oe, // High while miso is driven
   input wire logic [7:0] fixed_status_byte, // Device status for the upper byte
   input wire logic [7:0] ext_status, // Extended status for write answers
   input wire logic [7:0] device_flags, // Flags for flag reads
   output logic wr_pulse, // One cycle per executed write
   output logic [4:0] wr_addr, // Register of the executed write
   output logic [7:0] wr_data, // Payload of the executed write
   output logic wr_parity, // Parity bit sent with the write
   output logic select_stuck_low_flag // Select held low too long
);

   localparam int LEAD_MIN_CYC = (LEAD_MIN_NS * `SCF_CLK_MHZ + 999) / 1000;
   localparam int LEAD_MAX_CYC = `SCF_LEAD_MAX_NS * `SCF_CLK_MHZ / 1000;
   localparam int SW = $clog2(STUCK_CYC + 1);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [4:0] bit_cnt_reg; // Bits sampled this frame
   logic [14:0] rx_shift_reg; // Incoming bits so far
   logic [15:0] rx_hold_reg; // Last complete frame
   logic frame_tgl_reg; // Toggles once per complete frame
   logic [6:0] op_addr_reg; // Op code and register of this frame
   logic [4:0] tx_cnt_reg; // Bits driven this frame
   logic miso_reg; // Output bit
   logic miso_oe_reg; // Output enable, doubles as first edge marker
   logic [7:0] tx_low; // Lower answer byte for this frame
   logic [7:0] reg_mem [0:31]; // Register contents
   logic cs_s1, cs_s2; // Select synchroniser
   logic st_s1, st_s2; // First edge synchroniser
   logic tg_s1, tg_s2, tg_s3; // Frame toggle synchroniser
   logic [7:0] stat_snap_reg; // Status frozen during a frame
   logic [7:0] ext_snap_reg; // Extended status frozen during a frame
   logic [7:0] flag_snap_reg; // Flags frozen during a frame
   logic stuck_snap_reg; // Stuck flag frozen during a frame
   logic [7:0] lead_cnt_reg; // Select fall to first edge, in clk cycles
   logic [SW-1:0] stuck_cnt_reg; // Select low duration
   logic stuck_flag_reg; // Stuck low flag
   logic pend_reg; // Accepted write awaiting commit
   logic wr_pulse_reg;
   logic [4:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic wr_parity_reg;
   logic frame_done; // One cycle after a frame arrives
   scf_pkg::scf_op_e rx_op; // Op code of the last frame
   logic [4:0] rx_addr; // Register of the last frame
   logic write_ok; // Write passes the lead time check
   logic stuck_set; // Stuck condition reached
   logic stuck_clr; // Read frame clears the flag
   logic lead_in_window; // Lead time within bounds

   // Op codes 00 and 11 are reads
   function automatic logic is_read(input logic [1:0] op);
      return op == scf_pkg::SCF_OP_READ || op == scf_pkg::SCF_OP_FLAG;
   endfunction

   // ----------------------------------------
   // Link side, receive
   // ----------------------------------------
   // Bit counter and header capture; cleared whenever select is high
   always_ff @(negedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt_reg <= 5'h00;
         op_addr_reg <= 7'h00;
      end else begin
         if (bit_cnt_reg != `SCF_CNT_SAT) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
         if (bit_cnt_reg == `SCF_HDR_BIT) begin
            op_addr_reg <= {rx_shift_reg[5:0], mosi};
         end
      end
   end

   // Shift in; only the sixteenth bit hands a frame over
   always_ff @(negedge sclk or negedge nrst) begin
      if (!nrst) begin
         rx_shift_reg <= 15'h0000;
         rx_hold_reg <= 16'h0000;
         frame_tgl_reg <= 1'b0;
      end else begin
         rx_shift_reg <= {rx_shift_reg[13:0], mosi};
         if (!chip_select_n && bit_cnt_reg == `SCF_LAST_BIT) begin
            rx_hold_reg <= {rx_shift_reg, mosi};
            frame_tgl_reg <= ~frame_tgl_reg;
         end
      end
   end

   // ----------------------------------------
   // Link side, transmit
   // ----------------------------------------
   // Lower byte picked from the header; the register array and the
   // snapshots only change outside the read window, so they are quiet here
   always_comb begin
      case (op_addr_reg[6:5])
         scf_pkg::SCF_OP_READ: begin
            tx_low = reg_mem[op_addr_reg[4:0]];
         end
         scf_pkg::SCF_OP_FLAG: begin
            tx_low = flag_snap_reg;
            if (op_addr_reg[4:0] == `SCF_FLAG_ADDR) begin
               tx_low[`SCF_FLAG_POS] = stuck_snap_reg;
            end
         end
         default: begin
            tx_low = ext_snap_reg;
         end
      endcase
   end

   // Data changes on the rising edge, the host samples on the falling one
   always_ff @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         tx_cnt_reg <= 5'h00;
         miso_reg <= 1'b0;
         miso_oe_reg <= 1'b0;
      end else begin
         miso_oe_reg <= 1'b1;
         if (tx_cnt_reg < `SCF_LOW_START) begin
            miso_reg <= stat_snap_reg[3'h7 - tx_cnt_reg[2:0]];
         end else if (tx_cnt_reg <= `SCF_LAST_BIT) begin
            miso_reg <= tx_low[3'h7 - tx_cnt_reg[2:0]];
         end else begin
            miso_reg <= 1'b0;
         end
         if (tx_cnt_reg != `SCF_CNT_SAT) begin
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
         end
      end
   end

   assign miso = miso_reg;
   assign miso_oe = miso_oe_reg;

   // ----------------------------------------
   // Crossings into clk
   // ----------------------------------------
   // Select and first edge are levels; the frame is a toggle event
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         st_s1 <= 1'b0;
         st_s2 <= 1'b0;
         tg_s1 <= 1'b0;
         tg_s2 <= 1'b0;
         tg_s3 <= 1'b0;
      end else begin
         cs_s1 <= chip_select_n;
         cs_s2 <= cs_s1;
         st_s1 <= miso_oe_reg;
         st_s2 <= st_s1;
         tg_s1 <= frame_tgl_reg;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
      end
   end

   // ----------------------------------------
   // Frame decode
   // ----------------------------------------
   // The held frame is stable until the next sixteenth bit, many clk
   // cycles after the toggle is seen
   assign frame_done = tg_s2 ^ tg_s3;
   assign rx_op = scf_pkg::scf_op_e'(rx_hold_reg[`SCF_OP_HI:`SCF_OP_LO]);
   assign rx_addr = rx_hold_reg[`SCF_ADDR_HI:`SCF_ADDR_LO];
   assign lead_in_window = lead_cnt_reg >= 8'(LEAD_MIN_CYC) &&
      lead_cnt_reg <= 8'(LEAD_MAX_CYC);
   // Bit 8 is not checked; host keeps it per op code
   assign write_ok = rx_op == scf_pkg::SCF_OP_WRITE &&
      (!stuck_flag_reg || lead_in_window);
   assign stuck_set = !cs_s2 && stuck_cnt_reg == SW'(STUCK_CYC);
   assign stuck_clr = frame_done && is_read(rx_op);

   // Snapshots refresh only while select is high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_snap_reg <= 8'h00;
         ext_snap_reg <= 8'h00;
         flag_snap_reg <= 8'h00;
         stuck_snap_reg <= 1'b0;
      end else if (cs_s2) begin
         stat_snap_reg <= fixed_status_byte;
         ext_snap_reg <= ext_status;
         flag_snap_reg <= device_flags;
         stuck_snap_reg <= stuck_flag_reg;
      end
   end

   // Lead time; both ends pass an equal synchroniser so the lag cancels
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lead_cnt_reg <= 8'h00;
      end else if (cs_s2) begin
         lead_cnt_reg <= 8'h00;
      end else if (!st_s2 && lead_cnt_reg != `SCF_LEAD_SAT) begin
         lead_cnt_reg <= lead_cnt_reg + 8'h01;
      end
   end

   // Select low duration, saturating at the limit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stuck_cnt_reg <= '0;
      end else if (cs_s2) begin
         stuck_cnt_reg <= '0;
      end else if (stuck_cnt_reg != SW'(STUCK_CYC)) begin
         stuck_cnt_reg <= stuck_cnt_reg + SW'(1);
      end
   end

   // Stuck flag; a new stuck event wins over a clearing read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stuck_flag_reg <= 1'b0;
      end else if (stuck_set) begin
         stuck_flag_reg <= 1'b1;
      end else if (stuck_clr) begin
         stuck_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   // Accepted writes are committed two cycles after frame_done, long before any
   // following frame can finish
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_reg <= 1'b0;
         wr_pulse_reg <= 1'b0;
         wr_addr_reg <= 5'h00;
         wr_data_reg <= 8'h00;
         wr_parity_reg <= 1'b0;
      end else begin
         pend_reg <= frame_done && write_ok;
         wr_pulse_reg <= pend_reg;
         if (frame_done && write_ok) begin
            wr_addr_reg <= rx_addr;
            wr_data_reg <= rx_hold_reg[`SCF_DATA_HI:`SCF_DATA_LO];
            wr_parity_reg <= rx_hold_reg[`SCF_PN_BIT];
         end
      end
   end

   // Register array; reset fills every entry with the default
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 32; i++) begin
            reg_mem[i] <= `SCF_REG_RESET;
         end
      end else if (pend_reg) begin
         reg_mem[wr_addr_reg] <= wr_data_reg;
      end
   end

   assign wr_pulse = wr_pulse_reg;
   assign wr_addr = wr_addr_reg;
   assign wr_data = wr_data_reg;
   assign wr_parity = wr_parity_reg;
   assign select_stuck_low_flag = stuck_flag_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_write_taken;
      frame_done && write_ok;
   endsequence

   sequence s_write_commit;
      pend_reg ##1 (wr_pulse_reg && wr_addr_reg == $past(rx_addr, 2));
   endsequence

   a_write_commit: assert property (@(posedge clk) disable iff (!nrst)
      s_write_taken |=> s_write_commit) else $error("accepted write not committed");

   a_write_readback: assert property (@(posedge clk) disable iff (!nrst)
      wr_pulse_reg |-> reg_mem[wr_addr_reg] == wr_data_reg)
      else $error("written value not stored");

   a_window_block: assert property (@(posedge clk) disable iff (!nrst)
      (frame_done && stuck_flag_reg && lead_cnt_reg > 8'(LEAD_MAX_CYC)) |=>
      !pend_reg ##1 !wr_pulse_reg) else $error("write outside lead window executed");

   a_reserved_quiet: assert property (@(posedge clk) disable iff (!nrst)
      (frame_done && rx_op == scf_pkg::SCF_OP_RSVD) |=> !pend_reg)
      else $error("reserved op code changed state");

   a_stuck_sets: assert property (@(posedge clk) disable iff (!nrst)
      stuck_set |=> stuck_flag_reg) else $error("stuck flag not set");

   a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
      (stuck_clr && !stuck_set) |=> !stuck_flag_reg) else $error("read did not clear flag");

   a_lead_frozen: assert property (@(posedge clk) disable iff (!nrst)
      (st_s2 && !cs_s2 && !cs_s1) |=> lead_cnt_reg == $past(lead_cnt_reg))
      else $error("lead time moved after first edge");

   a_status_first: assert property (@(posedge sclk)
      disable iff (chip_select_n || !nrst)
      tx_cnt_reg == 5'h00 |=> miso_reg == stat_snap_reg[7])
      else $error("first output bit is not status bit 15");

   a_no_chain: assert property (@(posedge sclk)
      disable iff (chip_select_n || !nrst)
      tx_cnt_reg > `SCF_LAST_BIT |=> !miso_reg) else $error("bits shifted past frame");

   a_frame_hold: assert property (@(negedge sclk)
      disable iff (chip_select_n || !nrst)
      bit_cnt_reg == `SCF_LAST_BIT |=> rx_hold_reg[0] == $past(mosi))
      else $error("sixteenth bit not held");

endmodule

/* test/scf_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Host controller model for the serial link
// ----------------------------------------
module scf_host_model (
   output logic sclk, // Link clock, low outside frames
   output logic chip_select_n, // Frame select, active low
   output logic mosi, // Serial data to the device
   input wire logic miso, // Serial data from the device
   input wire logic miso_oe // High while the device drives miso
);
   localparam int HALF_NS = 6; // Half of the 12 ns link period
   localparam int CS_LOW_NS = 5600; // Select low just over 5.5 us per frame
   localparam int GAP_NS = 200; // Select high time, ten system clocks

   // Idle levels; select starts low for one step so that the link flops,
   // which see no sclk before the first frame, get a real clearing edge
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b0;
      mosi = 1'b0;
      #1 chip_select_n = 1'b1;
   end

   // One frame; tx is right aligned, rx collects MSB first
   task automatic xfer(input logic [31:0] tx, input int nbits, input int lead_ns,
                       output logic [31:0] rx);
      int lag_ns;
      rx = 32'h0000_0000;
      lag_ns = CS_LOW_NS - lead_ns - nbits * 2 * HALF_NS;
      if (lag_ns < 100) begin
         lag_ns = 100;
      end
      chip_select_n = 1'b0;
      #(lead_ns - 1);
      for (int i = nbits - 1; i >= 0; i--) begin
         mosi = tx[i];
         #1 sclk = 1'b1;
         #(HALF_NS) sclk = 1'b0;
         // An undriven line must never pass for data
         rx = {rx[30:0], (miso_oe === 1'b1) ? miso : 1'bx};
         #(HALF_NS - 1);
      end
      // Released line shows the inverse so stale data cannot look valid
      mosi = ~mosi;
      #(lag_ns) chip_select_n = 1'b1;
      #(GAP_NS);
   endtask

   // Select held low with no clocks, as a stuck trace would
   task automatic hold_low(input int ns);
      chip_select_n = 1'b0;
      #(ns) chip_select_n = 1'b1;
      #(GAP_NS);
   endtask
endmodule

/* test/sbc_spi_command_frame_bench.sv */
`timescale 1ns/1ps

module sbc_spi_command_frame_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, nrst, sclk, chip_select_n, mosi, miso, miso_oe;
   logic [7:0] fs_in, ext_in, flags_in; // Status sources
   logic wr_pulse, wr_parity, select_stuck_low_flag;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic [31:0] rx; // Last answer from the link
   int err_total = 0;
   int tests_run = 0;
   int wr_seen = 0; // Executed writes seen
   int wr_base = 0; // Count before the last frame

   // Shortened stuck time (8 us) keeps it above the 5.6 us frame
   scf_spi_frame #(.STUCK_CYC(400)) i_dut (.clk(clk), .nrst(nrst), .sclk(sclk),
      .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .fixed_status_byte(fs_in), .ext_status(ext_in), .device_flags(flags_in),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .wr_parity(wr_parity),
      .select_stuck_low_flag(select_stuck_low_flag));

   scf_host_model i_host (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe));

   // System clock, 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Count write pulses
   always @(posedge clk) begin
      if (wr_pulse === 1'b1) begin
         wr_seen <= wr_seen + 1;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Write effect: pulse count, then fields when a write was due
   task automatic chk_wr(input int n, input logic [4:0] a, input logic [7:0] d,
                         input logic p);
      tests_run++;
      if ((wr_seen - wr_base) != n || (n > 0 && {wr_addr, wr_data, wr_parity} !== {a, d, p}))
      begin
         err_total++;
         $display("mismatch write expected %0d %h %h %b seen %0d %h %h %b", n, a, d, p,
                  wr_seen - wr_base, wr_addr, wr_data, wr_parity);
      end
   endtask

   // Frame starts off a falling clk edge; the gap lets the write land
   task automatic spi(input logic [31:0] tx, input int nbits, input int lead_ns);
      wr_base = wr_seen;
      @(negedge clk);
      i_host.xfer(tx, nbits, lead_ns, rx);
      @(negedge clk);
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      // Reset falls after time zero so the sclk-only flops catch the edge
      nrst = 1'b1;
      fs_in = 8'ha5;
      ext_in = 8'h5a;
      flags_in = 8'h81;
      #1 nrst = 1'b0;
      repeat (10) @(negedge clk);
      chk("reset flag and oe", 16'h0000, {14'h0000, select_stuck_low_flag, miso_oe});
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      spi(32'h60c0, 16, 600);
      chk("write answer", 16'ha55a, rx[15:0]);
      chk_wr(1, 5'h10, 8'hc0, 1'b0);
      spi(32'h6733, 16, 600);
      chk_wr(1, 5'h13, 8'h33, 1'b1);
      spi(32'h2100, 16, 600);
      chk("read answer", 16'ha5c0, rx[15:0]);
      chk_wr(0, 5'h00, 8'h00, 1'b0);
      spi(32'h2500, 16, 600);
      chk("default readback", 16'ha500, rx[15:0]);
      spi(32'he100, 16, 600);
      chk("flag read", 16'ha581, rx[15:0]);
      spi(32'ha0ff, 16, 600);
      chk("reserved answer", 16'ha55a, rx[15:0]);
      chk_wr(0, 5'h00, 8'h00, 1'b0);
      spi(32'h2100, 16, 600);
      chk("after reserved", 16'ha5c0, rx[15:0]);
      spi(32'h60, 8, 600);
      chk_wr(0, 5'h00, 8'h00, 1'b0);
      spi(32'h6011ff, 24, 600);
      chk("long frame answer", 16'ha55a, rx[23:8]);
      chk("bits past frame", 16'h0000, {8'h00, rx[7:0]});
      chk_wr(1, 5'h10, 8'h11, 1'b0);
      // Select stuck low with no clocks
      i_host.hold_low(10000);
      chk("stuck flag set", 16'h0001, {15'h0000, select_stuck_low_flag});
      spi(32'h60c0, 16, 3000);
      chk_wr(0, 5'h00, 8'h00, 1'b0);
      // Lead time below the lower bound of the window is refused as well
      spi(32'h6022, 16, 200);
      chk_wr(0, 5'h00, 8'h00, 1'b0);
      spi(32'h6055, 16, 700);
      chk_wr(1, 5'h10, 8'h55, 1'b0);
      spi(32'he300, 16, 600);
      chk("stuck flag bit", 16'ha591, rx[15:0]);
      spi(32'h2580, 16, 600);
      chk("stuck flag cleared", 16'h0000, {15'h0000, select_stuck_low_flag});
      spi(32'h6077, 16, 3000);
      chk_wr(1, 5'h10, 8'h77, 1'b0);
      // New status while select is high must show in the next answer
      fs_in = 8'h3c;
      spi(32'h2100, 16, 600);
      chk("final readback", 16'h3c77, rx[15:0]);
      wrap_up();
   end

   // Hang guard: the whole run needs well under a millisecond
   initial begin
      #1000000;
      err_total++;
      $display("mismatch run time expected below 1 ms seen limit");
      wrap_up();
   end
endmodule
